/* pkg/ocd_consts.vh */
// constants for the measurement command decoder
`ifndef OCD_CONSTS_VH
`define OCD_CONSTS_VH

// ****************************************
// command codes
// ****************************************
`define OCD_CMD_RAW_BASE 8'ha0
`define OCD_CMD_OVS2 8'hac
`define OCD_CMD_OVS4 8'had
`define OCD_CMD_OVS8 8'hae
`define OCD_CMD_OVS16 8'haf
`define OCD_CMD_SEL_PRIMARY 8'hb0
`define OCD_CMD_SEL_SECONDARY 8'hb1
`define OCD_CMD_HALT 8'hbf
`define OCD_CMD_POLL_NIBBLE 4'hf

// ****************************************
// stored setup locations
// ****************************************
`define OCD_ADDR_PRIMARY_SETUP 8'h12
`define OCD_ADDR_SECONDARY_SETUP 8'h16

// ****************************************
// conversion kinds
// ****************************************
`define OCD_KIND_FULL 3'h0
`define OCD_KIND_SENSOR 3'h1
`define OCD_KIND_ZC_SENSOR 3'h2
`define OCD_KIND_TEMP 3'h3
`define OCD_KIND_ZC_TEMP 3'h4

// ****************************************
// status byte
// ****************************************
`define OCD_ST_POWERED 6
`define OCD_ST_BUSY 5
`define OCD_ST_MODE_HI 4
`define OCD_ST_MODE_LO 3
`define OCD_ST_MEM_ERR 2
`define OCD_ST_CFG_SEL 1
`define OCD_ST_SAT 0

// ****************************************
// widths and reset values
// ****************************************
`define OCD_DATA_W 24
`define OCD_SETUP_W 16
`define OCD_TEMP_IGNORE_MASK 16'h1fff
`define OCD_RESET_CFG_SEL 1'b0
`define OCD_SHIFT_OVS2 3'h1
`define OCD_SHIFT_OVS4 3'h2
`define OCD_SHIFT_OVS8 3'h3
`define OCD_SHIFT_OVS16 3'h4

`endif

/* src/ocd_event_sync.v */
// toggle-to-pulse event crossing into the system clock
`timescale 1ns/10ps
module ocd_event_sync (
    input wire i_clk,
    input wire i_rstn,
    input wire i_toggle,
    output reg o_pulse
);
    reg sync1;
    reg sync2;
    reg sync3;
    reg armed;

    // ****************************************
    // two-stage synchroniser and edge find
    // ****************************************
    // chain runs through reset so it follows the link level; no false edge after release
    always @(posedge i_clk) begin
        sync1 <= i_toggle;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // no edge reported until the last stage has settled after reset
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            armed <= 1'b0;
            o_pulse <= 1'b0;
        end else begin
            armed <= 1'b1;
            o_pulse <= armed && (sync2 ^ sync3);
        end
    end
endmodule

/* src/ocd_mean_acc.v */
// accumulator producing the mean of 2^shift samples
`timescale 1ns/10ps
module ocd_mean_acc #(
    parameter W = 24,
    parameter SW = 28
) (
    input wire i_clk,
    input wire i_rstn,
    input wire i_clear,
    input wire i_add,
    input wire [W-1:0] i_value,
    input wire [2:0] i_shift,
    output wire [W-1:0] o_mean
);
    reg [SW-1:0] sum;
    wire [SW-1:0] shifted;

    // ****************************************
    // sum and divide by 2^shift
    // ****************************************
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            sum <= {SW{1'b0}};
        end else if (i_clear) begin
            sum <= {SW{1'b0}};
        end else if (i_add) begin
            sum <= sum + {{(SW-W){1'b0}}, i_value};
        end
    end

    assign shifted = sum >> i_shift;
    assign o_mean = shifted[W-1:0];
endmodule

/* src/ocd_command_decoder.v */
// measurement command decoder of the sensor conditioner
// Summary of operation
// - AC: two corrected cycles, store their mean
// - AD: four corrected cycles, store their mean
// - AE: eight corrected cycles, store their mean
// - AF: sixteen corrected cycles, store their mean
// - oversampled cycles run back to back
// - oversampling stores sensor and temperature means at once
// - B0 selects primary setup, clears status bit1
// - B1 selects secondary setup, sets status bit1
// - BF powers down, halting measurement operation
// - Fx on SPI returns status and data
// - A0/A1 uncorrected sensor; A0 uses stored setup
// - A4/A5 temperature; even ones use fixed setup
// - odd raw commands use host setup word
// - host temperature setup ignores bits 15:13
// - raw result written; lsb picks setup source
// - busy blocks commands until data ready, except BF halt and Fx poll
`timescale 1ns/10ps
`include "ocd_consts.vh"
module ocd_command_decoder #(
    parameter DW = `OCD_DATA_W,
    parameter SETW = `OCD_SETUP_W,
    parameter [SETW-1:0] FIXED_TEMP_SETUP = 16'h0000
) (
    input wire I_CLK_SYS,
    input wire I_RSTN,
    input wire I_CMD_TOGGLE,
    input wire [7:0] I_CMD_BYTE,
    input wire [SETW-1:0] I_CMD_WORD,
    input wire I_CMD_FROM_SPI,
    input wire [SETW-1:0] I_PRIMARY_SETUP,
    input wire [SETW-1:0] I_SECONDARY_SETUP,
    input wire [1:0] I_MODE,
    input wire I_MEM_ERROR,
    input wire I_CONV_DONE,
    input wire I_ALU_SAT,
    input wire [DW-1:0] I_SENSOR_CORR,
    input wire [DW-1:0] I_TEMP_CORR,
    input wire [DW-1:0] I_RAW_RESULT,
    output reg O_CONV_START,
    output reg [2:0] O_CONV_KIND,
    output reg [SETW-1:0] O_FRONTEND_SETUP,
    output reg O_AWAKE,
    output reg O_BUSY,
    output reg O_CFG_SEL,
    output reg [DW-1:0] O_SENSOR_RESULT,
    output reg [DW-1:0] O_TEMP_RESULT,
    output reg [7:0] O_STATUS,
    output reg O_POLL_STB,
    output reg [7:0] O_POLL_STATUS,
    output reg [DW-1:0] O_POLL_DATA
);
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_FIN = 2'h3;
    localparam [7:0] RAW_BASE = `OCD_CMD_RAW_BASE;

    // ****************************************
    // declarations
    // ****************************************
    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] cmd_byte;
    reg [SETW-1:0] cmd_word;
    reg cmd_spi;
    reg cmd_ready;
    reg [2:0] shift;
    reg [4:0] cycle_cnt;
    reg is_raw;
    reg sat;
    reg next_busy;
    wire cmd_pulse;
    wire acc_clear;
    wire acc_add;
    wire [DW-1:0] sensor_mean;
    wire [DW-1:0] temp_mean;
    wire last_cycle;
    wire is_ovs;
    wire is_raw_cmd;
    wire is_poll;
    wire [7:0] status_now;

    // ****************************************
    // functions
    // ****************************************
    function [2:0] ovs_shift;
        input [7:0] code;
        begin
            if (code == `OCD_CMD_OVS2) begin
                ovs_shift = `OCD_SHIFT_OVS2;
            end else if (code == `OCD_CMD_OVS4) begin
                ovs_shift = `OCD_SHIFT_OVS4;
            end else if (code == `OCD_CMD_OVS8) begin
                ovs_shift = `OCD_SHIFT_OVS8;
            end else if (code == `OCD_CMD_OVS16) begin
                ovs_shift = `OCD_SHIFT_OVS16;
            end else begin
                ovs_shift = 3'h0;
            end
        end
    endfunction

    function [2:0] raw_kind;
        input [2:0] low;
        begin
            case (low[2:1])
                2'h0: raw_kind = `OCD_KIND_SENSOR;
                2'h1: raw_kind = `OCD_KIND_ZC_SENSOR;
                2'h2: raw_kind = `OCD_KIND_TEMP;
                default: raw_kind = `OCD_KIND_ZC_TEMP;
            endcase
        end
    endfunction

    function [SETW-1:0] raw_setup;
        input [2:0] low;
        input [SETW-1:0] host_word;
        input [SETW-1:0] stored_word;
        begin
            if (low[0] && low[2]) begin
                raw_setup = host_word & `OCD_TEMP_IGNORE_MASK;
            end else if (low[0]) begin
                raw_setup = host_word;
            end else if (low[2]) begin
                raw_setup = FIXED_TEMP_SETUP;
            end else begin
                raw_setup = stored_word;
            end
        end
    endfunction

    // ****************************************
    // command capture from the link side
    // ****************************************
    ocd_event_sync u_cmd_sync (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_toggle(I_CMD_TOGGLE),
        .o_pulse(cmd_pulse)
    );

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            cmd_byte <= 8'h00;
            cmd_word <= {SETW{1'b0}};
            cmd_spi <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= cmd_pulse;
            if (cmd_pulse) begin
                cmd_byte <= I_CMD_BYTE;
                cmd_word <= I_CMD_WORD;
                cmd_spi <= I_CMD_FROM_SPI;
            end
        end
    end

    assign is_ovs = (ovs_shift(cmd_byte) != 3'h0);
    assign is_raw_cmd = (cmd_byte[7:3] == RAW_BASE[7:3]);
    assign is_poll = (cmd_byte[7:4] == `OCD_CMD_POLL_NIBBLE) && cmd_spi;

    // ****************************************
    // averaging of sensor and temperature
    // ****************************************
    assign acc_clear = (state == ST_IDLE);
    assign acc_add = (state == ST_WAIT) && I_CONV_DONE && !is_raw;
    assign last_cycle = (cycle_cnt == (5'h01 << shift) - 5'h01);

    ocd_mean_acc #(
        .W(DW),
        .SW(DW + 4)
    ) u_sensor_acc (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_clear(acc_clear),
        .i_add(acc_add),
        .i_value(I_SENSOR_CORR),
        .i_shift(shift),
        .o_mean(sensor_mean)
    );

    ocd_mean_acc #(
        .W(DW),
        .SW(DW + 4)
    ) u_temp_acc (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_clear(acc_clear),
        .i_add(acc_add),
        .i_value(I_TEMP_CORR),
        .i_shift(shift),
        .o_mean(temp_mean)
    );

    // ****************************************
    // sequencer next state
    // ****************************************
    always @* begin
        next_state = state;
        next_busy = O_BUSY;
        case (state)
            ST_IDLE: begin
                if (cmd_ready && (is_ovs || is_raw_cmd)) begin
                    next_state = ST_START;
                    next_busy = 1'b1;
                end
            end
            ST_START: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (I_CONV_DONE && (is_raw || last_cycle)) begin
                    next_state = ST_FIN;
                end else if (I_CONV_DONE) begin
                    next_state = ST_START;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
            end
        endcase
        if (cmd_ready && cmd_byte == `OCD_CMD_HALT) begin
            next_state = ST_IDLE;
            next_busy = 1'b0;
        end
    end

    // ****************************************
    // sequencer registers
    // ****************************************
    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            state <= ST_IDLE;
            O_BUSY <= 1'b0;
            O_AWAKE <= 1'b0;
            O_CONV_START <= 1'b0;
            O_CONV_KIND <= `OCD_KIND_FULL;
            O_FRONTEND_SETUP <= {SETW{1'b0}};
            O_CFG_SEL <= `OCD_RESET_CFG_SEL;
            O_SENSOR_RESULT <= {DW{1'b0}};
            O_TEMP_RESULT <= {DW{1'b0}};
            shift <= 3'h0;
            cycle_cnt <= 5'h00;
            is_raw <= 1'b0;
            sat <= 1'b0;
        end else begin
            state <= next_state;
            O_BUSY <= next_busy;
            O_AWAKE <= (next_state != ST_IDLE);
            O_CONV_START <= (next_state == ST_START);
            if (state == ST_IDLE && cmd_ready && !O_BUSY) begin
                if (cmd_byte == `OCD_CMD_SEL_PRIMARY) begin
                    O_CFG_SEL <= 1'b0;
                    sat <= 1'b0;
                end else if (cmd_byte == `OCD_CMD_SEL_SECONDARY) begin
                    O_CFG_SEL <= 1'b1;
                    sat <= 1'b0;
                end else if (is_ovs) begin
                    shift <= ovs_shift(cmd_byte);
                    is_raw <= 1'b0;
                    O_CONV_KIND <= `OCD_KIND_FULL;
                    O_FRONTEND_SETUP <= O_CFG_SEL ? I_SECONDARY_SETUP : I_PRIMARY_SETUP;
                    sat <= 1'b0;
                end else if (is_raw_cmd) begin
                    shift <= 3'h0;
                    is_raw <= 1'b1;
                    O_CONV_KIND <= raw_kind(cmd_byte[2:0]);
                    O_FRONTEND_SETUP <= raw_setup(cmd_byte[2:0], cmd_word,
                        O_CFG_SEL ? I_SECONDARY_SETUP : I_PRIMARY_SETUP);
                    sat <= 1'b0;
                end else if (!is_poll) begin
                    sat <= 1'b0;
                end
            end
            if (state == ST_IDLE) begin
                cycle_cnt <= 5'h00;
            end else if (state == ST_WAIT && I_CONV_DONE) begin
                cycle_cnt <= cycle_cnt + 5'h01;
                if (!is_raw && I_ALU_SAT) begin
                    sat <= 1'b1;
                end
                if (is_raw) begin
                    O_SENSOR_RESULT <= I_RAW_RESULT;
                    O_TEMP_RESULT <= {DW{1'b0}};
                end
            end
            if (state == ST_FIN && !is_raw) begin
                O_SENSOR_RESULT <= sensor_mean;
                O_TEMP_RESULT <= temp_mean;
            end
        end
    end

    // ****************************************
    // status byte and poll answer
    // ****************************************
    assign status_now = {1'b0, 1'b1, O_BUSY, I_MODE, I_MEM_ERROR, O_CFG_SEL, sat};

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_STATUS <= 8'h00;
            O_POLL_STB <= 1'b0;
            O_POLL_STATUS <= 8'h00;
            O_POLL_DATA <= {DW{1'b0}};
        end else begin
            O_STATUS <= status_now;
            O_POLL_STB <= cmd_ready && is_poll;
            if (cmd_ready && is_poll) begin
                O_POLL_STATUS <= status_now;
                O_POLL_DATA <= O_SENSOR_RESULT;
            end
        end
    end
endmodule

/* verification/ocd_cmd_sva.sv */
// assertions for the measurement command decoder
`timescale 1ns/10ps
`include "ocd_consts.vh"
module ocd_cmd_sva #(
    parameter DW = 24,
    parameter SETW = 16
) (
    input wire I_CLK_SYS,
    input wire I_RSTN,
    input wire I_CMD_FROM_SPI,
    input wire [SETW-1:0] I_PRIMARY_SETUP,
    input wire [SETW-1:0] I_SECONDARY_SETUP,
    input wire I_CONV_DONE,
    input wire O_CONV_START,
    input wire [2:0] O_CONV_KIND,
    input wire [SETW-1:0] O_FRONTEND_SETUP,
    input wire O_AWAKE,
    input wire O_BUSY,
    input wire O_CFG_SEL,
    input wire [DW-1:0] O_SENSOR_RESULT,
    input wire [7:0] O_STATUS,
    input wire O_POLL_STB,
    input wire [DW-1:0] O_POLL_DATA
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);
    a_start_pulse: assert property (O_CONV_START |=> !O_CONV_START)
        else $error("start pulse longer than one cycle");
    a_start_busy: assert property (O_CONV_START |-> O_BUSY && O_AWAKE)
        else $error("conversion started while idle or asleep");
    a_full_setup: assert property (O_CONV_START && O_CONV_KIND == `OCD_KIND_FULL |->
        O_FRONTEND_SETUP == (O_CFG_SEL ? I_SECONDARY_SETUP : I_PRIMARY_SETUP))
        else $error("full measurement uses wrong stored setup");
    a_no_pause: assert property (I_CONV_DONE && O_BUSY && O_CONV_KIND == `OCD_KIND_FULL |=>
        (##[0:1] O_CONV_START) or (##[1:3] !O_BUSY))
        else $error("pause between oversampled cycles");
    a_cfg_status: assert property (O_STATUS[`OCD_ST_CFG_SEL] == $past(O_CFG_SEL))
        else $error("status setup bit disagrees with selection");
    a_busy_status: assert property (O_STATUS[`OCD_ST_BUSY] == $past(O_BUSY))
        else $error("status busy bit disagrees with busy");
    a_poll_data: assert property (O_POLL_STB |-> O_POLL_DATA == $past(O_SENSOR_RESULT))
        else $error("poll data is not the last result");
    a_poll_spi: assert property (O_POLL_STB |-> $past(I_CMD_FROM_SPI))
        else $error("poll answered for a non spi command");
    a_cfg_idle: assert property ($changed(O_CFG_SEL) |-> !$past(O_BUSY))
        else $error("selection changed while busy");
    c_poll: cover property (O_POLL_STB);
    c_done: cover property ($fell(O_BUSY));
    c_sel: cover property ($rose(O_CFG_SEL));
endmodule
bind ocd_command_decoder ocd_cmd_sva #(.DW(DW), .SETW(SETW)) u_ocd_cmd_sva (
    .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_CMD_FROM_SPI(I_CMD_FROM_SPI),
    .I_PRIMARY_SETUP(I_PRIMARY_SETUP), .I_SECONDARY_SETUP(I_SECONDARY_SETUP),
    .I_CONV_DONE(I_CONV_DONE), .O_CONV_START(O_CONV_START), .O_CONV_KIND(O_CONV_KIND),
    .O_FRONTEND_SETUP(O_FRONTEND_SETUP), .O_AWAKE(O_AWAKE), .O_BUSY(O_BUSY),
    .O_CFG_SEL(O_CFG_SEL), .O_SENSOR_RESULT(O_SENSOR_RESULT), .O_STATUS(O_STATUS),
    .O_POLL_STB(O_POLL_STB), .O_POLL_DATA(O_POLL_DATA));

/* verification/ocd_host_model.sv */
// host model sending command frames over the link
`timescale 1ns/10ps
module ocd_host_model (
    output logic o_toggle,
    output logic [7:0] o_byte,
    output logic [15:0] o_word,
    output logic o_spi
);
    logic lclk;
    initial begin
        lclk = 1'b0;
        o_toggle = 1'b0;
        o_byte = 8'h00;
        o_word = 16'h0000;
        o_spi = 1'b0;
    end
    // link clock runs only within a frame; lines go inverse once released
    task automatic send(input logic [7:0] b, input logic [15:0] w, input logic s);
        o_byte = b;
        o_word = (b[7:3] == 5'h14 && !b[0]) ? 16'h0000 : w;
        o_spi = s;
        #200 lclk = 1'b1;
        o_toggle = ~o_toggle;
        #200 lclk = 1'b0;
        #800 o_byte = ~o_byte;
        o_word = ~o_word;
        o_spi = ~o_spi;
    endtask
endmodule

/* verification/testbench.sv */
// self-checking bench for the measurement command decoder
`timescale 1ns/10ps
`include "ocd_consts.vh"
module testbench;
    typedef struct {logic [7:0] c; logic [15:0] w; logic [2:0] k; logic [15:0] s; int n;} ocd_row_t;
    localparam logic [15:0] PRI = 16'h1234;
    localparam logic [15:0] SEC = 16'h5678;
    logic I_CLK_SYS, I_RSTN, I_CONV_DONE, I_MEM_ERROR, I_ALU_SAT;
    logic [15:0] I_PRIMARY_SETUP, I_SECONDARY_SETUP;
    logic [23:0] I_SENSOR_CORR, I_TEMP_CORR, I_RAW_RESULT;
    logic [1:0] I_MODE;
    wire I_CMD_TOGGLE, I_CMD_FROM_SPI, O_CONV_START, O_AWAKE, O_BUSY, O_CFG_SEL, O_POLL_STB;
    wire [7:0] I_CMD_BYTE, O_STATUS, O_POLL_STATUS;
    wire [15:0] I_CMD_WORD, O_FRONTEND_SETUP;
    wire [2:0] O_CONV_KIND;
    wire [23:0] O_SENSOR_RESULT, O_TEMP_RESULT, O_POLL_DATA;
    int num_errors = 0;
    int tests_run = 0;
    int lat = 3;
    int cnt = 0;
    int starts = 0;
    int polls = 0;
    int sh;
    logic [2:0] kind_seen;
    logic [15:0] setup_seen;
    logic [27:0] s_sum, t_sum;
    logic [7:0] poll_st;
    logic [23:0] poll_dat, last_raw;
    ocd_row_t rows [12];
    ocd_command_decoder u_ocd_command_decoder (
        .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_CMD_TOGGLE(I_CMD_TOGGLE), .I_CMD_BYTE(I_CMD_BYTE),
        .I_CMD_WORD(I_CMD_WORD), .I_CMD_FROM_SPI(I_CMD_FROM_SPI), .I_PRIMARY_SETUP(I_PRIMARY_SETUP),
        .I_SECONDARY_SETUP(I_SECONDARY_SETUP), .I_MODE(I_MODE), .I_MEM_ERROR(I_MEM_ERROR),
        .I_CONV_DONE(I_CONV_DONE), .I_ALU_SAT(I_ALU_SAT), .I_SENSOR_CORR(I_SENSOR_CORR),
        .I_TEMP_CORR(I_TEMP_CORR), .I_RAW_RESULT(I_RAW_RESULT), .O_CONV_START(O_CONV_START),
        .O_CONV_KIND(O_CONV_KIND), .O_FRONTEND_SETUP(O_FRONTEND_SETUP), .O_AWAKE(O_AWAKE),
        .O_BUSY(O_BUSY), .O_CFG_SEL(O_CFG_SEL), .O_SENSOR_RESULT(O_SENSOR_RESULT),
        .O_TEMP_RESULT(O_TEMP_RESULT), .O_STATUS(O_STATUS), .O_POLL_STB(O_POLL_STB),
        .O_POLL_STATUS(O_POLL_STATUS), .O_POLL_DATA(O_POLL_DATA));
    ocd_host_model u_ocd_host_model (.o_toggle(I_CMD_TOGGLE), .o_byte(I_CMD_BYTE),
        .o_word(I_CMD_WORD), .o_spi(I_CMD_FROM_SPI));
    // ****
    // converter stand-in and output monitor
    // ****
    always @(posedge I_CLK_SYS) begin
        #1;
        I_CONV_DONE = (cnt == 1);
        if (cnt == 1) begin
            I_SENSOR_CORR = 24'h7ffff9 + 24'(starts * 3);
            I_TEMP_CORR = 24'h000201 + 24'(starts * 5);
            I_RAW_RESULT = 24'habc000 + 24'(starts);
            s_sum = s_sum + {4'h0, I_SENSOR_CORR};
            t_sum = t_sum + {4'h0, I_TEMP_CORR};
        end
        if (O_CONV_START) begin
            cnt = lat;
            starts = starts + 1;
            kind_seen = O_CONV_KIND;
            setup_seen = O_FRONTEND_SETUP;
        end else if (cnt != 0) begin
            cnt = cnt - 1;
        end
        if (O_POLL_STB) begin
            polls = polls + 1;
            poll_st = O_POLL_STATUS;
            poll_dat = O_POLL_DATA;
        end
    end
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic run(input logic [7:0] c, input logic [15:0] w);
        s_sum = 28'h0;
        t_sum = 28'h0;
        starts = 0;
        u_ocd_host_model.send(c, w, 1'b0);
        for (int i = 0; i < 2000 && O_BUSY !== 1'b0; i++) @(posedge I_CLK_SYS);
        if (O_BUSY !== 1'b0) chk("busy end", 24'h1, 24'h0);
        repeat (3) @(posedge I_CLK_SYS);
        #1;
    endtask
    task automatic results();
        $display("errors %0d tests %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        I_CLK_SYS = 1'b0;
        forever #25 I_CLK_SYS = ~I_CLK_SYS;
    end
    initial begin
        repeat (20000) @(posedge I_CLK_SYS);
        num_errors++;
        results();
    end
    // ****
    // main sequence
    // ****
    initial begin
        I_RSTN = 1'b0;
        I_ALU_SAT = 1'b0;
        I_MEM_ERROR = 1'b1;
        I_MODE = 2'b01;
        I_PRIMARY_SETUP = PRI;
        I_SECONDARY_SETUP = SEC;
        rows = '{'{8'hac, 16'h0, 3'h0, PRI, 2}, '{8'had, 16'h0, 3'h0, PRI, 4},
            '{8'hae, 16'h0, 3'h0, PRI, 8}, '{8'haf, 16'h0, 3'h0, PRI, 16},
            '{8'ha0, 16'h0, 3'h1, PRI, 1}, '{8'ha1, 16'hffff, 3'h1, 16'hffff, 1},
            '{8'ha2, 16'h0, 3'h2, PRI, 1}, '{8'ha3, 16'hffff, 3'h2, 16'hffff, 1},
            '{8'ha4, 16'h0, 3'h3, 16'h0, 1}, '{8'ha5, 16'hffff, 3'h3, 16'h1fff, 1},
            '{8'ha6, 16'h0, 3'h4, 16'h0, 1}, '{8'ha7, 16'hffff, 3'h4, 16'h1fff, 1}};
        repeat (16) @(posedge I_CLK_SYS);
        #1 I_RSTN = 1'b1;
        repeat (2) @(posedge I_CLK_SYS);
        #1;
        chk("reset status", {16'h0, O_STATUS}, 24'h00004c);
        foreach (rows[r]) begin
            run(rows[r].c, rows[r].w);
            chk("cycles", 24'(starts), 24'(rows[r].n));
            chk("kind", {21'h0, kind_seen}, {21'h0, rows[r].k});
            chk("setup", {8'h0, setup_seen}, {8'h0, rows[r].s});
            if (rows[r].n > 1) begin
                sh = $clog2(rows[r].n);
                chk("sensor mean", O_SENSOR_RESULT, 24'(s_sum >> sh));
                chk("temp mean", O_TEMP_RESULT, 24'(t_sum >> sh));
            end else begin
                chk("raw", O_SENSOR_RESULT, I_RAW_RESULT);
                chk("raw temp", O_TEMP_RESULT, 24'h0);
            end
        end
        run(`OCD_CMD_SEL_SECONDARY, 16'h0);
        chk("status sel", {23'h0, O_STATUS[`OCD_ST_CFG_SEL]}, 24'h1);
        I_ALU_SAT = 1'b1;
        run(`OCD_CMD_OVS2, 16'h0);
        I_ALU_SAT = 1'b0;
        chk("setup sec", {8'h0, setup_seen}, {8'h0, SEC});
        chk("sat set", {23'h0, O_STATUS[`OCD_ST_SAT]}, 24'h1);
        run(8'ha2, 16'h0);
        last_raw = I_RAW_RESULT;
        chk("raw sec", {8'h0, setup_seen}, {8'h0, SEC});
        chk("sat clear", {23'h0, O_STATUS[`OCD_ST_SAT]}, 24'h0);
        run(`OCD_CMD_SEL_PRIMARY, 16'h0);
        chk("status pri", {23'h0, O_STATUS[`OCD_ST_CFG_SEL]}, 24'h0);
        lat = 8;
        starts = 0;
        u_ocd_host_model.send(`OCD_CMD_OVS16, 16'h0, 1'b0);
        u_ocd_host_model.send(`OCD_CMD_SEL_SECONDARY, 16'h0, 1'b0);
        chk("sel busy", {23'h0, O_CFG_SEL}, 24'h0);
        u_ocd_host_model.send(8'hf3, 16'h0, 1'b1);
        chk("poll", 24'(polls), 24'h1);
        chk("poll status", {16'h0, poll_st}, 24'h00006c);
        chk("poll data", poll_dat, last_raw);
        u_ocd_host_model.send(8'hf0, 16'h0, 1'b0);
        chk("i2c poll", 24'(polls), 24'h1);
        u_ocd_host_model.send(`OCD_CMD_HALT, 16'h0, 1'b0);
        chk("halt", {22'h0, O_BUSY, O_AWAKE}, 24'h0);
        chk("halt early", {23'h0, starts < 16}, 24'h1);
        repeat (20) @(posedge I_CLK_SYS);
        #1;
        run(`OCD_CMD_SEL_SECONDARY, 16'h0);
        I_RSTN = 1'b0;
        repeat (4) @(posedge I_CLK_SYS);
        #1 I_RSTN = 1'b1;
        repeat (2) @(posedge I_CLK_SYS);
        #1;
        chk("reset sel", {23'h0, O_CFG_SEL}, 24'h0);
        results();
    end
endmodule
